// >>> design/sgd_pkg.sv
// Purpose: Shared constants and types for the scatter-gather descriptor DMA pair.
// Assumes: Byte-addressed descriptors on 64-byte boundaries inside a 1 KiB window.
// Notes: Descriptor words and control register offsets are named here once.
package sgd_pkg;
  localparam int SGD_LEN_W = 23;
  localparam int SGD_FQ_DEPTH = 4;
  localparam int SGD_UQ_DEPTH = 4;
  localparam int SGD_MEM_WORDS = 256;
  // Descriptor word byte offsets.
  localparam logic [31:0] SGD_OFS_NEXT = 32'h00000000;
  localparam logic [31:0] SGD_OFS_BUF = 32'h00000008;
  localparam logic [31:0] SGD_OFS_CTRL = 32'h00000018;
  localparam logic [31:0] SGD_OFS_STS = 32'h0000001c;
  localparam logic [31:0] SGD_OFS_APP = 32'h00000020;
  localparam int SGD_NEXT_LSB = 6;
  // Control word fields.
  localparam int SGD_CTRL_SOF = 27;
  localparam int SGD_CTRL_EOF = 26;
  // Status word fields.
  localparam int SGD_STS_CMPLT = 31;
  localparam int SGD_STS_RX_PACKET_START_FLAG = 27;
  localparam int SGD_STS_RX_PACKET_END_FLAG = 26;
  localparam logic [3:0] SGD_CTL_TAG = 4'ha;
  // Controller register map on AXI4-Lite.
  localparam int SGD_AXI_AW = 13;
  localparam int SGD_MEM_SEL = 12;
  localparam logic [11:0] SGD_REG_CTRL = 12'h000;
  localparam logic [11:0] SGD_REG_STATUS = 12'h004;
  localparam logic [11:0] SGD_REG_CURDESC = 12'h008;
  localparam logic [11:0] SGD_REG_TAILDESC = 12'h010;
  localparam int SGD_CTRL_RUN = 0;
  localparam int SGD_CTRL_SOFT = 1;
  localparam int SGD_CTRL_SIDE = 2;
  localparam int SGD_CTRL_RX = 3;
  localparam logic [1:0] SGD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SGD_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] ptr;
    logic [31:0] nxt;
    logic [31:0] buf_addr;
    logic [31:0] ctrl;
    logic [31:0] app;
  } sgd_fq_ent_t;

  typedef enum logic [1:0] {
    SGD_M_IDLE = 2'b00,
    SGD_M_FETCH = 2'b01,
    SGD_M_WB = 2'b10
  } sgd_mstate_t;

  function automatic logic [31:0] sgd_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// >>> design/sgd_link_if.sv
// Purpose: Link between the descriptor engine and its controller with descriptor memory.
// Assumes: Both ends share aclk.
// Notes: Memory requests hold until a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
interface sgd_link_if;
  logic run_stop;
  logic soft_reset;
  logic side_stream_enable;
  logic rx_mode;
  logic cur_load;
  logic [31:0] cur_value;
  logic tail_write;
  logic [31:0] tail_value;
  logic halted_flag;
  logic paused_flag;
  logic descriptor_fetch_error;
  logic [31:0] cur_ptr;
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic mem_ack;
  logic [31:0] mem_rdata;
  modport dev (input run_stop, soft_reset, side_stream_enable, rx_mode, cur_load, cur_value,
    tail_write, tail_value, mem_ack, mem_rdata, output halted_flag, paused_flag,
    descriptor_fetch_error, cur_ptr, mem_req, mem_we, mem_addr, mem_wdata);
  modport ctl (output run_stop, soft_reset, side_stream_enable, rx_mode, cur_load, cur_value,
    tail_write, tail_value, mem_ack, mem_rdata, input halted_flag, paused_flag,
    descriptor_fetch_error, cur_ptr, mem_req, mem_we, mem_addr, mem_wdata);
endinterface
`default_nettype wire

// >>> design/sgd_queue.sv
// Purpose: Small descriptor queue used for prefetch and for pending write-back.
// Assumes: Caller never pushes when full nor pops when empty.
// Notes: Head entry is visible without a pop.
`timescale 1ns/1ps
`default_nettype none
module sgd_queue
  import sgd_pkg::*;
#(
  parameter int W = 32,
  parameter int DEPTH = 4
)(
  input wire logic aclk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sgd_q_st_t;
  sgd_q_st_t s;
  sgd_q_st_t n;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = din;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.mem[s.rp];
  assign full = (s.cnt == (AW+1)'(DEPTH));
  assign empty = (s.cnt == '0);
endmodule
`default_nettype wire

// >>> design/sgd_engine.sv
// Purpose: Device end; walks the descriptor ring, feeds the transfer engine, writes back status.
// Assumes: Transfer engine returns one status per command, in command order.
// Notes: One channel; rx_mode picks the receive or transmit meaning of the flags.
// Operation
// - Descriptors link into a ring via next pointers.
// - Transmit packet spans start flag to end flag.
// - Receive start flag marks first packet descriptor.
// - Long receive packet spills into following descriptors.
// - Receive end flag marks descriptor holding last byte.
// - Status field gets bytes moved per descriptor.
// - Four stream resets low on reset or soft reset.
// - Process in ring order, pause after tail descriptor.
// - Tail write while paused restarts fetching.
// - Tail write while busy just moves the stop.
// - Software loads pointer, runs, then writes tail.
// - Prefetch while not at tail and queue free.
// - Fetch pointer follows next; current shows active.
// - Error halts and points current at culprit, or at a descriptor issued in the same cycle.
// - Write back only after transfer status returns.
// - Write-back sets completed bit for software.
// - Software reuses completed descriptors, then moves tail.
// - Transmit start descriptor resets realignment logic.
// - Side stream carries only start descriptor words.
// - Side stream off: user words never read.
// - Side stream may stall either way, any time.
// - First side word carries tag in top bits.
// - Fetched completed descriptor is stale: error, halt.
`timescale 1ns/1ps
`default_nettype none
module sgd_engine
  import sgd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sgd_link_if.dev link,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [31:0] cmd_addr,
  output logic [SGD_LEN_W-1:0] cmd_len,
  output logic cmd_sof,
  output logic cmd_eof,
  input wire logic sts_valid,
  output logic sts_ready,
  input wire logic [SGD_LEN_W-1:0] sts_bytes,
  input wire logic sts_eop,
  input wire logic sts_err,
  output logic realign_reset,
  output logic ctl_tvalid,
  input wire logic ctl_tready,
  output logic [31:0] ctl_tdata,
  output logic ctl_tlast,
  output logic tx_data_reset_out_n,
  output logic tx_side_reset_out_n,
  output logic rx_data_reset_out_n,
  output logic rx_side_reset_out_n
);
  typedef struct packed {
    sgd_mstate_t mstate;
    logic [2:0] widx;
    logic [31:0] fetch_ptr;
    logic [31:0] tail;
    logic [31:0] cur_ptr;
    logic fetch_done;
    logic dma_err;
    logic fetch_err;
    logic halted;
    logic paused;
    sgd_fq_ent_t ent;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic cmd_valid;
    logic [31:0] cmd_addr;
    logic [SGD_LEN_W-1:0] cmd_len;
    logic cmd_sof;
    logic cmd_eof;
    logic realign;
    logic [1:0] ctl_cnt;
    logic [31:0] ctl_app;
    logic ctl_valid;
    logic [31:0] ctl_data;
    logic ctl_last;
    logic sts_ready;
    logic wb_pend;
    logic [31:0] wb_word;
    logic rx_in_pkt;
    logic [3:0] rst_n;
  } sgd_dev_st_t;

  sgd_dev_st_t s;
  sgd_dev_st_t n;
  logic q_rst_n;
  logic fq_push;
  logic fq_pop;
  logic fq_full;
  logic fq_empty;
  sgd_fq_ent_t fq_head;
  logic uq_pop;
  logic uq_full;
  logic uq_empty;
  logic [31:0] uq_head;
  logic run;
  logic last_word;

  function automatic logic [31:0] word_ofs(input logic [2:0] idx);
    case (idx)
      3'h0: return SGD_OFS_NEXT;
      3'h1: return SGD_OFS_BUF;
      3'h2: return SGD_OFS_CTRL;
      3'h3: return SGD_OFS_STS;
      default: return SGD_OFS_APP;
    endcase
  endfunction

  // Queues clear on soft reset too, so no stale descriptor survives a restart.
  assign q_rst_n = aresetn && !link.soft_reset;

  sgd_queue #(.W($bits(sgd_fq_ent_t)), .DEPTH(SGD_FQ_DEPTH)) u_fetch_q (
    .aclk(aclk),
    .rst_n(q_rst_n),
    .push(fq_push),
    .din(n.ent),
    .pop(fq_pop),
    .dout(fq_head),
    .full(fq_full),
    .empty(fq_empty)
  );

  sgd_queue #(.W(32), .DEPTH(SGD_UQ_DEPTH)) u_update_q (
    .aclk(aclk),
    .rst_n(q_rst_n),
    .push(fq_pop),
    .din(fq_head.ptr),
    .pop(uq_pop),
    .dout(uq_head),
    .full(uq_full),
    .empty(uq_empty)
  );

  always_comb begin
    n = s;
    fq_push = 1'b0;
    fq_pop = 1'b0;
    uq_pop = 1'b0;
    last_word = 1'b0;
    run = link.run_stop && !s.dma_err && !s.fetch_err;
    n.realign = 1'b0;
    n.rst_n = 4'hf;
    if (link.cur_load) begin
      n.fetch_ptr = link.cur_value;
      n.cur_ptr = link.cur_value;
    end
    if (link.tail_write) begin
      n.tail = link.tail_value;
      // Clearing the stop both restarts a paused ring and moves a live one.
      n.fetch_done = 1'b0;
    end
    if (s.cmd_valid && cmd_ready) begin
      n.cmd_valid = 1'b0;
    end
    if (s.ctl_valid && ctl_tready) begin
      if (s.ctl_cnt == 2'h1) begin
        n.ctl_data = s.ctl_app;
        n.ctl_last = 1'b1;
        n.ctl_cnt = 2'h2;
      end else begin
        n.ctl_valid = 1'b0;
        n.ctl_last = 1'b0;
        n.ctl_cnt = 2'h0;
      end
    end
    if (s.sts_ready && sts_valid) begin
      if (sts_err) begin
        n.dma_err = 1'b1;
        n.cur_ptr = uq_head;
      end else begin
        n.wb_pend = 1'b1;
        n.wb_word = '0;
        n.wb_word[SGD_STS_CMPLT] = 1'b1;
        n.wb_word[SGD_LEN_W-1:0] = sts_bytes;
        if (link.rx_mode) begin
          n.wb_word[SGD_STS_RX_PACKET_START_FLAG] = !s.rx_in_pkt;
          n.wb_word[SGD_STS_RX_PACKET_END_FLAG] = sts_eop;
          n.rx_in_pkt = !sts_eop;
        end
      end
    end
    case (s.mstate)
      SGD_M_IDLE: begin
        if (s.wb_pend) begin
          n.mstate = SGD_M_WB;
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = uq_head + SGD_OFS_STS;
          n.mem_wdata = s.wb_word;
        end else if (run && !s.fetch_done && !fq_full) begin
          n.mstate = SGD_M_FETCH;
          n.widx = 3'h0;
          n.ent.ptr = s.fetch_ptr;
          n.ent.app = '0;
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
          n.mem_addr = s.fetch_ptr + SGD_OFS_NEXT;
        end
      end
      SGD_M_FETCH: begin
        if (link.mem_ack) begin
          case (s.widx)
            3'h0: n.ent.nxt = link.mem_rdata;
            3'h1: n.ent.buf_addr = link.mem_rdata;
            3'h2: n.ent.ctrl = link.mem_rdata;
            3'h3: n.ent.app = '0;
            default: n.ent.app = link.mem_rdata;
          endcase
          // User words are read only for a transmit ring with the side stream on.
          last_word = (s.widx == 3'h4) || ((s.widx == 3'h3) &&
                      !(link.side_stream_enable && !link.rx_mode));
          if ((s.widx == 3'h3) && link.mem_rdata[SGD_STS_CMPLT]) begin
            n.fetch_err = 1'b1;
            n.cur_ptr = s.ent.ptr;
            n.mem_req = 1'b0;
            n.mstate = SGD_M_IDLE;
          end else if (last_word) begin
            fq_push = 1'b1;
            n.fetch_ptr = {s.ent.nxt[31:SGD_NEXT_LSB], SGD_NEXT_LSB'(0)};
            n.fetch_done = (s.ent.ptr == s.tail) && !link.tail_write;
            n.mem_req = 1'b0;
            n.mstate = SGD_M_IDLE;
          end else begin
            n.widx = s.widx + 3'h1;
            n.mem_addr = s.ent.ptr + word_ofs(s.widx + 3'h1);
          end
        end
      end
      SGD_M_WB: begin
        if (link.mem_ack) begin
          n.mem_req = 1'b0;
          n.mem_we = 1'b0;
          n.wb_pend = 1'b0;
          uq_pop = 1'b1;
          n.mstate = SGD_M_IDLE;
        end
      end
      default: n.mstate = SGD_M_IDLE;
    endcase
    // A start descriptor waits for a free side stream so its words are never dropped.
    if (run && !fq_empty && !n.cmd_valid && !uq_full && (n.ctl_cnt == 2'h0)) begin
      fq_pop = 1'b1;
      n.cur_ptr = fq_head.ptr;
      n.cmd_valid = 1'b1;
      n.cmd_addr = fq_head.buf_addr;
      n.cmd_len = fq_head.ctrl[SGD_LEN_W-1:0];
      n.cmd_sof = fq_head.ctrl[SGD_CTRL_SOF] && !link.rx_mode;
      n.cmd_eof = fq_head.ctrl[SGD_CTRL_EOF] && !link.rx_mode;
      if (fq_head.ctrl[SGD_CTRL_SOF] && !link.rx_mode) begin
        n.realign = 1'b1;
        if (link.side_stream_enable) begin
          n.ctl_cnt = 2'h1;
          n.ctl_valid = 1'b1;
          n.ctl_last = 1'b0;
          n.ctl_data = {SGD_CTL_TAG, 28'h0000000};
          n.ctl_app = fq_head.app;
        end
      end
    end
    n.sts_ready = !n.wb_pend && run;
    n.halted = !run;
    n.paused = run && s.fetch_done && fq_empty && uq_empty && !s.cmd_valid &&
               !s.wb_pend && (s.mstate == SGD_M_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || link.soft_reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign link.halted_flag = s.halted;
  assign link.paused_flag = s.paused;
  assign link.descriptor_fetch_error = s.fetch_err;
  assign link.cur_ptr = s.cur_ptr;
  assign link.mem_req = s.mem_req;
  assign link.mem_we = s.mem_we;
  assign link.mem_addr = s.mem_addr;
  assign link.mem_wdata = s.mem_wdata;
  assign cmd_valid = s.cmd_valid;
  assign cmd_addr = s.cmd_addr;
  assign cmd_len = s.cmd_len;
  assign cmd_sof = s.cmd_sof;
  assign cmd_eof = s.cmd_eof;
  assign sts_ready = s.sts_ready;
  assign realign_reset = s.realign;
  assign ctl_tvalid = s.ctl_valid;
  assign ctl_tdata = s.ctl_data;
  assign ctl_tlast = s.ctl_last;
  assign tx_data_reset_out_n = s.rst_n[0];
  assign tx_side_reset_out_n = s.rst_n[1];
  assign rx_data_reset_out_n = s.rst_n[2];
  assign rx_side_reset_out_n = s.rst_n[3];
endmodule
`default_nettype wire

// >>> design/sgd_ctrl.sv
// Purpose: Far end; AXI4-Lite registers for software plus the descriptor memory.
// Assumes: Software keeps to one outstanding write and one outstanding read.
// Notes: Memory window aliases low ten address bits; higher bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module sgd_ctrl
  import sgd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sgd_link_if.ctl link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [SGD_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [SGD_AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef struct packed {
    logic aw_got;
    logic [SGD_AXI_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic cur_load;
    logic [31:0] cur_val;
    logic tail_wr;
    logic [31:0] tail_val;
    logic ack;
    logic [31:0] mem_rdata;
  } sgd_ctl_st_t;

  sgd_ctl_st_t s;
  sgd_ctl_st_t n;
  logic [31:0] mem [SGD_MEM_WORDS];
  logic axi_we;
  logic [7:0] axi_idx;
  logic [31:0] axi_wd;
  logic dev_we;
  logic [31:0] v;

  always_comb begin
    n = s;
    axi_we = 1'b0;
    axi_idx = s.awaddr[9:2];
    axi_wd = sgd_merge(mem[s.awaddr[9:2]], s.wdata, s.wstrb);
    dev_we = 1'b0;
    v = '0;
    n.ctrl[SGD_CTRL_SOFT] = 1'b0;
    n.cur_load = 1'b0;
    n.tail_wr = 1'b0;
    n.ack = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = SGD_RESP_OKAY;
      if (s.awaddr[SGD_MEM_SEL]) begin
        axi_we = 1'b1;
      end else begin
        case (s.awaddr[11:0])
          SGD_REG_CTRL: begin
            v = sgd_merge({28'h0000000, s.ctrl}, s.wdata, s.wstrb);
            n.ctrl = v[3:0];
            // Soft reset also stops the ring, so software must rearm it.
            n.ctrl[SGD_CTRL_RUN] = v[SGD_CTRL_RUN] && !v[SGD_CTRL_SOFT];
          end
          SGD_REG_CURDESC: begin
            n.cur_val = sgd_merge(s.cur_val, s.wdata, s.wstrb);
            n.cur_load = 1'b1;
          end
          SGD_REG_TAILDESC: begin
            n.tail_val = sgd_merge(s.tail_val, s.wdata, s.wstrb);
            n.tail_wr = 1'b1;
          end
          default: n.bresp = SGD_RESP_SLVERR;
        endcase
      end
    end
    n.awready = !n.aw_got;
    n.wready = !n.w_got;
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = SGD_RESP_OKAY;
      n.rdata = '0;
      if (s_axi_araddr[SGD_MEM_SEL]) begin
        n.rdata = mem[s_axi_araddr[9:2]];
      end else begin
        case (s_axi_araddr[11:0])
          SGD_REG_CTRL: n.rdata = {28'h0000000, s.ctrl};
          SGD_REG_STATUS: n.rdata = {29'h00000000, link.descriptor_fetch_error,
                                     link.paused_flag, link.halted_flag};
          SGD_REG_CURDESC: n.rdata = link.cur_ptr;
          SGD_REG_TAILDESC: n.rdata = s.tail_val;
          default: n.rresp = SGD_RESP_SLVERR;
        endcase
      end
    end
    n.arready = !n.rvalid;
    if (link.mem_req && !s.ack) begin
      n.ack = 1'b1;
      n.mem_rdata = mem[link.mem_addr[9:2]];
      dev_we = link.mem_we;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Engine write-back lands after a software write to the same word in one cycle.
  always_ff @(posedge aclk) begin
    if (axi_we) begin
      mem[axi_idx] <= axi_wd;
    end
    if (dev_we) begin
      mem[link.mem_addr[9:2]] <= link.mem_wdata;
    end
  end

  assign link.run_stop = s.ctrl[SGD_CTRL_RUN];
  assign link.soft_reset = s.ctrl[SGD_CTRL_SOFT];
  assign link.side_stream_enable = s.ctrl[SGD_CTRL_SIDE];
  assign link.rx_mode = s.ctrl[SGD_CTRL_RX];
  assign link.cur_load = s.cur_load;
  assign link.cur_value = s.cur_val;
  assign link.tail_write = s.tail_wr;
  assign link.tail_value = s.tail_val;
  assign link.mem_ack = s.ack;
  assign link.mem_rdata = s.mem_rdata;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
endmodule
`default_nettype wire

// >>> verification/sgd_link_checker.sv
// Purpose: Watches the link between the descriptor engine and its controller.
// Assumes: One clock; aresetn is synchronous and active low.
// Notes: Only link signals are seen; stream-side resets are judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module sgd_link_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run_stop,
  input wire logic soft_reset,
  input wire logic tail_write,
  input wire logic halted_flag,
  input wire logic paused_flag,
  input wire logic descriptor_fetch_error,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_addr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence mem_wait_s;
    mem_req && !mem_ack;
  endsequence
  sequence err_twice_s;
    descriptor_fetch_error ##1 descriptor_fetch_error;
  endsequence
  mem_hold_a: assert property (mem_wait_s |=> mem_req && $stable(mem_addr))
    else $error("memory request moved before its acknowledge");
  ack_next_a: assert property (mem_wait_s |=> mem_ack)
    else $error("memory acknowledge late");
  ack_pulse_a: assert property (mem_ack |=> !mem_ack)
    else $error("memory acknowledge longer than one cycle");
  soft_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  stop_halt_a: assert property (!run_stop [*3] |-> halted_flag)
    else $error("stopped engine not halted");
  err_halt_a: assert property (err_twice_s |-> halted_flag)
    else $error("fetch error without halt");
  err_hold_a: assert property (descriptor_fetch_error && !soft_reset
    |=> descriptor_fetch_error)
    else $error("fetch error cleared without soft reset");
  pause_idle_a: assert property (paused_flag |-> !mem_req)
    else $error("memory traffic while paused");
  tail_wake_a: assert property (paused_flag && tail_write |-> ##[1:6] mem_req)
    else $error("tail write did not restart fetching");
  wake_c: cover property (paused_flag && tail_write);
endmodule
`default_nettype wire

// >>> verification/sg_descriptor_dma_tb.sv
// Purpose: Runs the engine and controller together through ring, restart, stale and soft reset.
// Assumes: Bench plays the transfer engine and the stream target.
// Notes: Stream ready toggles every cycle so the side stream is stalled every other cycle.
`timescale 1ns/1ps
`default_nettype none
module sg_descriptor_dma_tb
  import sgd_pkg::*;
;
  localparam logic [12:0] RC = {1'b0, SGD_REG_CTRL};
  localparam logic [12:0] RS = {1'b0, SGD_REG_STATUS};
  localparam logic [12:0] RD = {1'b0, SGD_REG_CURDESC};
  localparam logic [12:0] RT = {1'b0, SGD_REG_TAILDESC};
  localparam logic [31:0] SE = (32'h1 << SGD_CTRL_SOF) | (32'h1 << SGD_CTRL_EOF);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cmd_ready = 1'b0, sts_valid = 1'b0, sts_eop = 1'b0, sts_err = 1'b0, ctl_tready = 1'b0;
  logic cmd_valid, cmd_sof, cmd_eof, sts_ready, realign_reset, ctl_tvalid, ctl_tlast;
  logic [31:0] cmd_addr, ctl_tdata;
  logic [SGD_LEN_W-1:0] cmd_len;
  logic [SGD_LEN_W-1:0] sts_bytes = '0;
  logic tx_data_reset_out_n, tx_side_reset_out_n, rx_data_reset_out_n, rx_side_reset_out_n;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [SGD_AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic armed = 1'b0;
  logic [31:0] words[$];
  int failures = 0, checked = 0, n_realign = 0, n_low = 0;
  sgd_link_if link();
  sgd_engine i_sgd_engine (.*);
  sgd_ctrl i_sgd_ctrl (.*);
  sgd_link_checker i_sgd_link_checker (.aclk, .aresetn, .run_stop(link.run_stop),
    .soft_reset(link.soft_reset), .tail_write(link.tail_write),
    .halted_flag(link.halted_flag), .paused_flag(link.paused_flag),
    .descriptor_fetch_error(link.descriptor_fetch_error), .mem_req(link.mem_req),
    .mem_ack(link.mem_ack), .mem_addr(link.mem_addr));
  always #25 aclk = ~aclk;
  // The target stalls every other cycle to exercise stream back-pressure.
  always @(posedge aclk) begin
    ctl_tready <= ~ctl_tready;
    if (ctl_tvalid && ctl_tready) words.push_back(ctl_tdata);
    if (realign_reset) n_realign++;
    if (armed && !tx_data_reset_out_n) n_low++;
  end
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [12:0] ma(input logic [9:0] o, input logic [31:0] w);
    return 13'h1000 + 13'(o) + w[12:0];
  endfunction
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic until_sts(input logic [31:0] m);
    do begin
      rd(RS, v);
    end while ((v & m) != m);
  endtask
  task automatic desc(input logic [9:0] o, input logic [31:0] nx, input logic [31:0] app);
    wr(ma(o, SGD_OFS_NEXT), nx);
    wr(ma(o, SGD_OFS_BUF), 32'h200 + 32'(o));
    wr(ma(o, SGD_OFS_CTRL), SE + 32'h10 + 32'(o));
    wr(ma(o, SGD_OFS_STS), 32'h0);
    wr(ma(o, SGD_OFS_APP), app);
  endtask
  // Plays the transfer engine: takes one command, then returns its status.
  task automatic xfer(input logic [31:0] ea, input logic [SGD_LEN_W-1:0] el,
                      input logic [SGD_LEN_W-1:0] by, input logic [1:0] f);
    cmd_ready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!cmd_valid);
    chk("cmd addr", ea, cmd_addr);
    chk("cmd len", {9'h0, el}, {9'h0, cmd_len});
    chk("cmd start end", {30'h0, f}, {30'h0, cmd_sof, cmd_eof});
    cmd_ready <= 1'b0;
    sts_bytes <= by;
    sts_valid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!sts_ready);
    sts_valid <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge aclk);
    chk("reset outs", 32'h0, {28'h0, tx_data_reset_out_n, tx_side_reset_out_n,
      rx_data_reset_out_n, rx_side_reset_out_n});
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("reset outs", 32'hf, {28'h0, tx_data_reset_out_n, tx_side_reset_out_n,
      rx_data_reset_out_n, rx_side_reset_out_n});
    rd(13'h020, v);
    chk("unmapped resp", {30'h0, SGD_RESP_SLVERR}, {30'h0, resp});
    $display("test reset done");
    desc(10'h000, 32'h40, 32'h11110001);
    desc(10'h040, 32'h0, 32'h22220002);
    wr(RD, 32'h0);
    wr(RC, 32'h5);
    wr(RT, 32'h40);
    xfer(32'h200, 23'h10, 23'h10, 2'h3);
    xfer(32'h240, 23'h50, 23'h4c, 2'h3);
    until_sts(32'h2);
    chk("status", 32'h2, v);
    rd(ma(10'h000, SGD_OFS_STS), v);
    chk("written back", 32'h80000010, v);
    rd(ma(10'h040, SGD_OFS_STS), v);
    chk("written back", 32'h8000004c, v);
    rd(RD, v);
    chk("current", 32'h40, v);
    chk("side count", 32'h4, 32'(words.size()));
    chk("side tag", 32'ha0000000, words[0]);
    chk("side user", 32'h11110001, words[1]);
    chk("side user", 32'h22220002, words[3]);
    chk("realign", 32'h2, 32'(n_realign));
    $display("test ring done");
    wr(ma(10'h000, SGD_OFS_STS), 32'h0);
    wr(RT, 32'h0);
    xfer(32'h200, 23'h10, 23'h8, 2'h3);
    until_sts(32'h2);
    rd(ma(10'h000, SGD_OFS_STS), v);
    chk("written back", 32'h80000008, v);
    $display("test restart done");
    wr(RT, 32'h40);
    until_sts(32'h5);
    chk("status", 32'h5, v);
    rd(RD, v);
    chk("current", 32'h40, v);
    $display("test stale done");
    armed <= 1'b1;
    wr(RC, 32'h2);
    repeat (4) @(posedge aclk);
    chk("reset low cycles", 32'h1, 32'(n_low));
    rd(RS, v);
    chk("status", 32'h1, v);
    $display("test soft reset done");
    wr(ma(10'h000, SGD_OFS_STS), 32'h0);
    wr(RD, 32'h0);
    wr(RC, 32'h9);
    sts_eop <= 1'b1;
    wr(RT, 32'h0);
    xfer(32'h200, 23'h10, 23'h6, 2'h0);
    until_sts(32'h2);
    rd(ma(10'h000, SGD_OFS_STS), v);
    chk("rx written back", 32'h8c000006, v);
    $display("test rx done");
    summarize();
  end
endmodule
`default_nettype wire
